// file: hdl/i2c_master_transaction_sequencer.sv
// Functional notes
// - 10-bit first byte 11110XX plus direction
// - interrupt while tx enabled and holding empty; the code masks it while a byte comes in or a read address goes out
// - start bit: START then load shift register
// - transmit interrupt after first bit shifted
// - slave low in ack slot sets ack
// - missing ack sets nack flag, clears ack
// - stop sent, stop and nack flag cleared
// - no nack interrupt when stop/start already set
// - end with stop or restart, clear bit
// - received byte answered nack if requested, else ack
// - received byte sets full flag and interrupt
// - host read clears full; nak near end
// - nack interrupt after last read byte, then stop
// - host write clears transmit-empty flag
// - ack cleared when disabled, not on read
`timescale 1ns/10ps
`default_nettype none
`include "i2c_seq_map.svh"

module i2c_master_transaction_sequencer
    import i2c_seq_pkg::*;
#(
    parameter int QUARTER = `I2C_QUARTER_CYC    // clock cycles per quarter scl period
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // host data port
    input  wire logic       data_wr,            // write strobe for data_holding_reg
    input  wire logic [7:0] data_wdata,         // byte written by the host
    input  wire logic       data_rd,            // read strobe for data_holding_reg
    output logic [7:0]      data_holding_reg,   // byte read by the host
    // host control
    input  wire logic       unit_enable,        // controller enable level
    input  wire logic       tx_irq_enable,      // transmit interrupt enable level
    input  wire ctrl_s      ctrl,               // one-cycle control pulses
    // host status
    output var status_s     status,             // status flags
    output logic            irq,                // interrupt level
    // i2c pins, open drain
    input  wire logic       scl_in,             // scl wire level
    output logic            scl_out,            // scl output value, always low
    output logic            scl_oe_n,           // low pulls scl low
    input  wire logic       sda_in,             // sda wire level
    output logic            sda_out,            // sda output value, always low
    output logic            sda_oe_n            // low pulls sda low
);

    // ======================================================================
    // internal state
    // ======================================================================
    state_e      state;           // sequencer state
    logic [1:0]  phase;           // quarter within the scl period
    logic [2:0]  bit_cnt;         // bit index within the byte
    logic [7:0]  shift;           // shift register, msb on the wire first
    logic        addr_byte;       // byte in flight follows a start
    logic        addr_lsb;        // direction bit of that address byte
    logic        rd_mode;         // bytes after the address are received
    logic        ack_seen;        // slave held sda low in the ack slot
    logic [15:0] div_cnt;         // quarter period divider
    logic        tick;            // one-cycle quarter enable
    logic        stretch;         // slave holds scl low
    logic        scl_meta;        // scl synchroniser, first stage
    logic        scl_s;           // scl synchronised
    logic        sda_meta;        // sda synchroniser, first stage
    logic        sda_s;           // sda synchronised
    // one-cycle events from the sequencer to the flag logic
    logic        ev_first_bit;
    logic        ev_rx_done;
    logic        ev_ack_set;
    logic        ev_ack_clr;
    logic        ev_nack_irq;
    logic        ev_nak_clr;
    logic        ev_start_done;
    logic        ev_stop_done;

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    // both pins come from the bus, so two flops before any logic
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
        end
    end

    // output values are fixed low; only the enables move
    always_ff @(posedge clk) begin
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end

    // ======================================================================
    // quarter period divider
    // ======================================================================
    // free running while enabled, so every phase lasts a full quarter
    always_ff @(posedge clk) begin
        if (!nrst || !unit_enable) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else if (div_cnt == 16'(QUARTER - 1)) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick    <= 1'b0;
        end
    end

    // scl released but still low: a slave is stretching the clock
    assign stretch = (phase == `I2C_PH_HIGH) && !scl_s;

    // ======================================================================
    // transaction sequencer
    // ======================================================================
    always_ff @(posedge clk) begin
        if (!nrst || !unit_enable) begin
            // disabled: bus released, sequence abandoned
            state         <= ST_IDLE;
            phase         <= `I2C_PH_DRIVE;
            bit_cnt       <= `I2C_BIT_FIRST;
            shift         <= `I2C_DATA_RESET;
            addr_byte     <= 1'b0;
            addr_lsb      <= 1'b0;
            rd_mode       <= 1'b0;
            ack_seen      <= 1'b0;
            scl_oe_n      <= 1'b1;
            sda_oe_n      <= 1'b1;
            ev_first_bit  <= 1'b0;
            ev_rx_done    <= 1'b0;
            ev_ack_set    <= 1'b0;
            ev_ack_clr    <= 1'b0;
            ev_nack_irq   <= 1'b0;
            ev_nak_clr    <= 1'b0;
            ev_start_done <= 1'b0;
            ev_stop_done  <= 1'b0;
        end else begin
            // events last one cycle
            ev_first_bit  <= 1'b0;
            ev_rx_done    <= 1'b0;
            ev_ack_set    <= 1'b0;
            ev_ack_clr    <= 1'b0;
            ev_nack_irq   <= 1'b0;
            ev_nak_clr    <= 1'b0;
            ev_start_done <= 1'b0;
            ev_stop_done  <= 1'b0;
            if (state == ST_IDLE) begin
                // idle does not wait for a tick, start phase aligns later
                phase <= `I2C_PH_DRIVE;
                if (status.start_pending) begin
                    state <= ST_START;
                end
            end else if (tick && !stretch) begin
                phase <= phase + 2'd1;
                case (state)
                    // start from idle and repeated start share one sequence
                    ST_START: begin
                        case (phase)
                            `I2C_PH_DRIVE: sda_oe_n <= 1'b1;
                            `I2C_PH_RISE:  scl_oe_n <= 1'b1;
                            `I2C_PH_HIGH:  sda_oe_n <= 1'b0;
                            default: begin
                                scl_oe_n      <= 1'b0;
                                shift         <= data_holding_reg;
                                addr_byte     <= 1'b1;
                                addr_lsb      <= data_holding_reg[0];
                                rd_mode       <= 1'b0;
                                bit_cnt       <= `I2C_BIT_FIRST;
                                ev_start_done <= 1'b1;
                                state         <= ST_BIT;
                            end
                        endcase
                    end
                    // one bit: drive while low, sample while high
                    ST_BIT: begin
                        case (phase)
                            `I2C_PH_DRIVE: begin
                                // receiving releases sda for the slave
                                sda_oe_n <= rd_mode ? 1'b1 : shift[7];
                            end
                            `I2C_PH_RISE:  scl_oe_n <= 1'b1;
                            `I2C_PH_HIGH: begin
                                if (rd_mode) begin
                                    shift <= {shift[6:0], sda_s};
                                end
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                if (!rd_mode) begin
                                    shift <= {shift[6:0], 1'b0};
                                end
                                if (!rd_mode && bit_cnt == `I2C_BIT_FIRST) begin
                                    ev_first_bit <= 1'b1;
                                end
                                if (bit_cnt == `I2C_BIT_LAST) begin
                                    ev_rx_done <= rd_mode;
                                    state      <= ST_ACK;
                                end
                                bit_cnt <= bit_cnt - 3'd1;
                            end
                        endcase
                    end
                    // ninth clock: sample slave ack or send our own
                    ST_ACK: begin
                        case (phase)
                            `I2C_PH_DRIVE: begin
                                // low drive is ack unless auto-nack requested
                                sda_oe_n <= rd_mode ? status.nak_pending : 1'b1;
                            end
                            `I2C_PH_RISE:  scl_oe_n <= 1'b1;
                            `I2C_PH_HIGH:  ack_seen <= !sda_s;
                            default: begin
                                scl_oe_n  <= 1'b0;
                                addr_byte <= 1'b0;
                                state     <= ST_HOLD;
                                if (rd_mode) begin
                                    if (status.nak_pending) begin
                                        ev_nack_irq <= 1'b1;
                                        ev_ack_clr  <= 1'b1;
                                        ev_nak_clr  <= 1'b1;
                                    end else begin
                                        ev_ack_set  <= 1'b1;
                                    end
                                end else if (ack_seen) begin
                                    ev_ack_set <= 1'b1;
                                    rd_mode    <= addr_byte && addr_lsb;
                                end else begin
                                    ev_ack_clr <= 1'b1;
                                    // a pending stop or start hides the nack
                                    if (!status.stop_pending && !status.start_pending) begin
                                        ev_nack_irq <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                    // scl kept low until the host has done its part
                    ST_HOLD: begin
                        phase <= `I2C_PH_DRIVE;
                        if (status.stop_pending) begin
                            state <= ST_STOP;
                        end else if (status.start_pending) begin
                            state <= ST_START;
                        end else if (status.nack_irq_flag) begin
                            state <= ST_HOLD;
                        end else if (rd_mode) begin
                            // next byte only once the last one was taken
                            if (!status.rx_holding_full) begin
                                bit_cnt <= `I2C_BIT_FIRST;
                                state   <= ST_BIT;
                            end
                        end else if (!status.tx_holding_empty) begin
                            shift   <= data_holding_reg;
                            bit_cnt <= `I2C_BIT_FIRST;
                            state   <= ST_BIT;
                        end
                    end
                    // stop: sda rises while scl is high
                    ST_STOP: begin
                        case (phase)
                            `I2C_PH_DRIVE: sda_oe_n <= 1'b0;
                            `I2C_PH_RISE:  scl_oe_n <= 1'b1;
                            `I2C_PH_HIGH:  sda_oe_n <= 1'b1;
                            default: begin
                                rd_mode      <= 1'b0;
                                ev_stop_done <= 1'b1;
                                state        <= ST_IDLE;
                            end
                        endcase
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ======================================================================
    // data holding register
    // ======================================================================
    // a received byte overrides a host write in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_holding_reg <= `I2C_DATA_RESET;
        end else if (ev_rx_done) begin
            data_holding_reg <= shift;
        end else if (data_wr) begin
            data_holding_reg <= data_wdata;
        end
    end

    // ======================================================================
    // status flags
    // ======================================================================
    // every hardware set wins over a clear arriving in the same cycle, except that disable clears ack over its set
    always_ff @(posedge clk) begin
        if (!nrst) begin
            status.tx_holding_empty <= `I2C_TX_EMPTY_RESET;
            status.rx_holding_full  <= 1'b0;
            status.ack              <= 1'b0;
            status.nack_irq_flag    <= 1'b0;
            status.start_pending    <= 1'b0;
            status.stop_pending     <= 1'b0;
            status.nak_pending      <= 1'b0;
        end else begin
            // emptied by the first bit or by a flush, filled by a write
            if (ev_first_bit || ctrl.flush) begin
                status.tx_holding_empty <= 1'b1;
            end else if (data_wr) begin
                status.tx_holding_empty <= 1'b0;
            end
            if (ev_rx_done) begin
                status.rx_holding_full <= 1'b1;
            end else if (data_rd) begin
                status.rx_holding_full <= 1'b0;
            end
            // a status read has no effect here
            if (!unit_enable) begin
                status.ack <= 1'b0;
            end else if (ev_ack_set) begin
                status.ack <= 1'b1;
            end else if (ev_ack_clr) begin
                status.ack <= 1'b0;
            end
            if (ev_nack_irq) begin
                status.nack_irq_flag <= 1'b1;
            end else if (ev_stop_done || !unit_enable) begin
                status.nack_irq_flag <= 1'b0;
            end
            if (ctrl.start_set) begin
                status.start_pending <= 1'b1;
            end else if (ev_start_done) begin
                status.start_pending <= 1'b0;
            end
            if (ctrl.stop_set) begin
                status.stop_pending <= 1'b1;
            end else if (ev_stop_done) begin
                status.stop_pending <= 1'b0;
            end
            if (ctrl.nak_set) begin
                status.nak_pending <= 1'b1;
            end else if (ev_nak_clr) begin
                status.nak_pending <= 1'b0;
            end
        end
    end

    // ======================================================================
    // interrupt
    // ======================================================================
    // the empty flag is masked while a byte is coming in, or while a read
    // address is going out, since no transmit data is wanted then
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= unit_enable
                && ((tx_irq_enable && status.tx_holding_empty
                     && !(rd_mode && (state == ST_BIT || state == ST_ACK))
                     && !(addr_byte && addr_lsb))
                    || status.rx_holding_full
                    || status.nack_irq_flag);
        end
    end

endmodule : i2c_master_transaction_sequencer
`default_nettype wire

// file: inc/i2c_seq_map.svh
`ifndef I2C_SEQ_MAP_SVH
`define I2C_SEQ_MAP_SVH

// ==========================================================================
// timing
// ==========================================================================
// system clock period in ns
`define I2C_CLK_PERIOD_NS     10
// one quarter of an scl period in ns (100 kHz bus)
`define I2C_QUARTER_NS        2500
// quarter period in clock cycles, rounded down (a longest time)
`define I2C_QUARTER_CYC       (`I2C_QUARTER_NS / `I2C_CLK_PERIOD_NS)

// ==========================================================================
// byte and bit phases
// ==========================================================================
// index of the first (most significant) bit of a byte
`define I2C_BIT_FIRST         3'd7
// index of the last bit of a byte
`define I2C_BIT_LAST          3'd0
// quarter phases of one scl period
`define I2C_PH_DRIVE          2'd0
`define I2C_PH_RISE           2'd1
`define I2C_PH_HIGH           2'd2
`define I2C_PH_FALL           2'd3

// ==========================================================================
// reset values
// ==========================================================================
`define I2C_TX_EMPTY_RESET    1'b1
`define I2C_DATA_RESET        8'h00

`endif

// file: inc/i2c_seq_pkg.sv
package i2c_seq_pkg;

    // ======================================================================
    // sequencer states, one-hot
    // ======================================================================
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,   // bus released, waiting for start
        ST_START = 6'b000010,   // start or repeated start condition
        ST_BIT   = 6'b000100,   // one data or address bit
        ST_ACK   = 6'b001000,   // acknowledge slot
        ST_HOLD  = 6'b010000,   // scl held low, waiting on the host
        ST_STOP  = 6'b100000    // stop condition
    } state_e;

    // ======================================================================
    // host control pulses, one cycle each
    // ======================================================================
    typedef struct packed {
        logic start_set;        // request start / repeated start
        logic stop_set;         // request stop
        logic nak_set;          // answer next received byte with nack
        logic flush;            // discard the holding register
    } ctrl_s;

    // ======================================================================
    // status seen by the host
    // ======================================================================
    typedef struct packed {
        logic tx_holding_empty; // holding register may be written
        logic rx_holding_full;  // received byte waiting
        logic ack;              // last byte was acknowledged
        logic nack_irq_flag;    // not-acknowledge event
        logic start_pending;    // start bit still set
        logic stop_pending;     // stop bit still set
        logic nak_pending;      // auto-nack request still set
    } status_s;

endpackage : i2c_seq_pkg

// file: testbench/i2c_seq_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// flag, interrupt and bus-edge properties, seen at the top ports only
module i2c_seq_properties
    import i2c_seq_pkg::*;
#(
    parameter int QUARTER = 4       // quarter scl period in clocks
) (
    // clock, reset and host side
    input wire logic    clk,
    input wire logic    nrst,
    input wire logic    data_rd,
    input wire logic    unit_enable,
    input wire logic    tx_irq_enable,
    input wire ctrl_s   ctrl,
    input wire status_s status,
    input wire logic    irq,
    // open-drain enables
    input wire logic    scl_oe_n,
    input wire logic    sda_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // idle bus only: receiving or a read address would mask the request
    a_irq_tx_empty: assert property (unit_enable && tx_irq_enable && status.tx_holding_empty
        && !status.start_pending && scl_oe_n && sda_oe_n |-> ##[1:2] irq) else $error("tx irq");
    a_irq_on_nack: assert property (unit_enable && status.nack_irq_flag |=> irq)
        else $error("nack irq missing");
    a_irq_on_full: assert property (unit_enable && status.rx_holding_full |=> irq)
        else $error("rx irq missing");
    a_read_clears_full: assert property (data_rd && status.rx_holding_full
        |=> !status.rx_holding_full) else $error("full flag kept after read");
    a_disable_clears: assert property (!unit_enable |=> !status.ack && !status.nack_irq_flag
        && scl_oe_n && sda_oe_n) else $error("disable left state");
    // with scl released, sda may only fall for a start and, unless the unit was just disabled, rise for a stop
    a_start_edge_only: assert property ($fell(sda_oe_n) && scl_oe_n && $past(scl_oe_n)
        |-> $past(status.start_pending)) else $error("sda fell with scl high");
    a_stop_edge_only: assert property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n)
        && $past(unit_enable) |-> $past(status.stop_pending)) else $error("sda rose");
    a_stop_then_clear: assert property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n)
        && $past(unit_enable) |-> ##[1:1000] !status.stop_pending && !status.nack_irq_flag)
        else $error("stop bits not cleared");
    a_flush_empties: assert property (ctrl.flush |=> status.tx_holding_empty)
        else $error("flush ignored");
endmodule : i2c_seq_properties
bind i2c_master_transaction_sequencer i2c_seq_properties #(.QUARTER(QUARTER)) props (.clk(clk),
    .nrst(nrst), .data_rd(data_rd), .unit_enable(unit_enable), .tx_irq_enable(tx_irq_enable),
    .ctrl(ctrl), .status(status), .irq(irq), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
`default_nettype wire

// file: testbench/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// behavioural slave: acks unless told not to, returns one fixed byte
module i2c_slave_model (
    // bus wires after the wired-and
    input wire logic       scl,
    input wire logic       sda,
    // scenario control
    input wire logic       ack_en,     // low answers every byte with nack
    input wire logic [7:0] tx_byte,    // byte sent on reads
    // pin and monitor
    output logic           sda_oe_n,   // low pulls sda low
    output logic [7:0]     got         // last byte seen on the bus
);
    int   cnt = 0;                     // scl falls since the byte began
    logic addr = 0, rd = 0, rdn = 0;   // address byte, sending now, sending next
    initial {sda_oe_n, got} = 9'h100;
    // start restarts framing; the fall that ends start is not a bit
    always @(negedge sda) if (scl === 1'b1) {cnt, addr, rd, sda_oe_n} = {-32'sd1, 3'b101};
    always @(posedge sda) if (scl === 1'b1) {cnt, rd} = {32'sd0, 1'b0};
    // sample while scl is high; a master nack ends the read
    always @(posedge scl) begin
        if (cnt < 8) got = {got[6:0], sda};
        if (cnt == 8 && rd && sda) rdn = 0;
    end
    // sda only moves after scl has fallen
    always @(negedge scl) begin
        cnt = cnt + 1;
        if (cnt == 8) begin
            sda_oe_n = rd | !ack_en;
            if (!rd) rdn = addr & got[0] & ack_en;
        end else if (cnt == 9) begin
            {cnt, addr, rd} = {32'sd0, 1'b0, rdn};
            sda_oe_n = !rd | tx_byte[7];
        end else if (rd) sda_oe_n = tx_byte[7 - cnt];
    end
endmodule : i2c_slave_model
`default_nettype wire

// file: testbench/i2c_master_transaction_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_transaction_sequencer_tb
    import i2c_seq_pkg::*;
;
    // ======================================================================
    // host side, wired-and sda with pull-up; slave never stretches scl
    logic clk = 0, nrst = 0, data_wr = 0, data_rd = 0, unit_enable = 0, tx_irq_enable = 0;
    logic [7:0] data_wdata = 8'h00, data_holding_reg, got;
    logic irq, scl_oe_n, sda_oe_n, s_oe_n, ack_en = 1;
    ctrl_s ctrl = '0;
    status_s status;
    wire logic sda = sda_oe_n & s_oe_n;
    int bad_count = 0, compares = 0;
    always #5 clk = ~clk;
    // quarter of 4 clocks gives the 160 ns link clock
    i2c_master_transaction_sequencer #(.QUARTER(4)) dut (.clk(clk), .nrst(nrst),
        .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
        .data_holding_reg(data_holding_reg), .unit_enable(unit_enable),
        .tx_irq_enable(tx_irq_enable), .ctrl(ctrl), .status(status), .irq(irq),
        .scl_in(scl_oe_n), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
        .sda_oe_n(sda_oe_n));
    i2c_slave_model slave (.scl(scl_oe_n), .sda(sda), .ack_en(ack_en), .tx_byte(8'hc3),
        .sda_oe_n(s_oe_n), .got(got));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // one host access, strobes high for exactly one cycle
    task automatic host(input logic wr, rd, input logic [7:0] b, input logic [3:0] c);
        @(negedge clk);
        {data_wr, data_rd, data_wdata, ctrl} = {wr, rd, b, c};
        @(negedge clk);
        {data_wr, data_rd, ctrl} = 6'h00;
    endtask : host
    // bounded wait on one status bit (6 empty .. 0 nak)
    task automatic wait_bit(input int idx, input logic v);
        int n;
        for (n = 0; n < 4000 && status[idx] !== v; n++) @(negedge clk);
        if (n == 4000) begin chk("wait", 8'h00, 8'h01); report_and_stop(); end
    endtask : wait_bit
    task automatic t_write();
        chk("status", 8'(status), 8'h40);
        {unit_enable, tx_irq_enable} = 2'b11;
        repeat (3) @(negedge clk);
        chk("irq", 8'(irq), 8'h01);
        host(1, 0, 8'hf6, 4'h0);
        chk("status", 8'(status), 8'h00);
        host(0, 0, 8'h00, 4'h8);
        wait_bit(6, 1);
        @(negedge clk);
        chk("irq", 8'(irq), 8'h01);
        host(1, 0, 8'h5a, 4'h0);
        wait_bit(4, 1);
        chk("first byte", got, 8'hf6);
        chk("status", 8'(status), 8'h10);
        ack_en = 0;
        wait_bit(6, 1);
        tx_irq_enable = 0;
        host(0, 0, 8'h00, 4'h4);
        wait_bit(4, 0);
        chk("last byte", got, 8'h5a);
        wait_bit(1, 0);
        chk("status", 8'(status), 8'h40);
    endtask : t_write
    task automatic t_nack();
        tx_irq_enable = 1;
        host(1, 0, 8'hf0, 4'h8);
        wait_bit(3, 1);
        @(negedge clk);
        chk("status", 8'(status), 8'h48);
        chk("irq", 8'(irq), 8'h01);
        tx_irq_enable = 0;
        host(0, 0, 8'h00, 4'h5);
        wait_bit(1, 0);
        chk("status", 8'(status), 8'h40);
    endtask : t_nack
    task automatic t_read();
        {ack_en, tx_irq_enable} = 2'b11;
        host(1, 0, 8'hf6, 4'h8);
        wait_bit(6, 1);
        host(1, 0, 8'h3c, 4'h0);
        wait_bit(6, 1);
        tx_irq_enable = 0;
        host(1, 0, 8'hf7, 4'ha);
        wait_bit(3, 1);
        @(negedge clk);
        chk("status", 8'(status), 8'h68);
        chk("rx data", data_holding_reg, 8'hc3);
        chk("irq", 8'(irq), 8'h01);
        host(0, 1, 8'h00, 4'h4);
        chk("status", 8'(status), 8'h4a);
        wait_bit(1, 0);
        chk("status", 8'(status), 8'h40);
    endtask : t_read
    // disable in mid-transfer: flags and bus must drop at once
    task automatic t_off();
        host(1, 0, 8'h10, 4'h8);
        wait_bit(4, 1);
        unit_enable = 0;
        repeat (2) @(negedge clk);
        chk("status", 8'(status), 8'h40);
        chk("bus", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    endtask : t_off
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1;
        t_write();
        t_nack();
        t_read();
        t_off();
        report_and_stop();
    end
endmodule : i2c_master_transaction_sequencer_tb
`default_nettype wire
